// [design/lss_lane_setting_select.sv]
// Purpose: Per-channel setting select from straps or serial bytes
// Assumes: Strap pads resolve to low/open/high codes; SCL is slow
// Notes:   SDA is open drain; out is always low, oe pulls the line
`timescale 1ns/1ns
`default_nettype none
module lss_lane_setting_select (
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_in,
  input  wire logic                     host_ctl_in,
  input  wire logic                     power_down_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_a_equalizer_strap_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_a_swing_strap_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_a_deemph_strap_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_b_equalizer_strap_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_b_swing_strap_in,
  input  wire logic [lss_pkg::STRAP_W-1:0] chan_b_deemph_strap_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_out,
  output logic [3:0]                    chan_a_eq_out,
  output logic [1:0]                    chan_a_swing_out,
  output logic [1:0]                    chan_a_deemph_out,
  output logic [3:0]                    chan_b_eq_out,
  output logic [1:0]                    chan_b_swing_out,
  output logic [1:0]                    chan_b_deemph_out,
  output logic                          chan_enable_out,
  output logic                          in_term_50_out,
  output logic                          out_term_50_out
);
  import lss_pkg::*;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic [1:0] strap_raw [NUM_STRAP];
  logic [1:0] strap_m [NUM_STRAP];
  logic [1:0] strap_s [NUM_STRAP];
  logic [1:0] ctl_m, ctl_s, mode_m, mode_s;
  logic host_s, pd_s, scl_s, sda_s, scl_p, sda_p;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] set_q [NUM_CHAN];
  logic [3:0] eq_q [NUM_CHAN];
  logic [1:0] sw_q [NUM_CHAN];
  logic [1:0] de_q [NUM_CHAN];
  logic [1:0] settle_q;
  logic loaded_q, chan_en_q, term_q, sda_oe_q, sda_zero_q;
  lss_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q, rd_q, rd_next;
  logic [1:0] ptr_q;
  logic rw_q, filler_q, nack_q;
  logic [6:0] my_addr;
  logic byte_done, wr_commit;

  // Any level other than low or high counts as open
  function automatic logic [3:0] map_eq(input logic [1:0] s);
    return (s == STRAP_LOW) ? EQ_LOW : (s == STRAP_HIGH) ? EQ_HIGH : EQ_OPEN;
  endfunction
  function automatic logic [1:0] map_sw(input logic [1:0] s);
    return (s == STRAP_LOW) ? SW_LOW : (s == STRAP_HIGH) ? SW_HIGH : SW_OPEN;
  endfunction
  function automatic logic [1:0] map_de(input logic [1:0] s);
    return (s == STRAP_LOW) ? DE_LOW : (s == STRAP_HIGH) ? DE_HIGH : DE_OPEN;
  endfunction

  assign strap_raw[STRAP_EQ] = chan_a_equalizer_strap_in;
  assign strap_raw[STRAP_SW] = chan_a_swing_strap_in;
  assign strap_raw[STRAP_DE] = chan_a_deemph_strap_in;
  assign strap_raw[3 + STRAP_EQ] = chan_b_equalizer_strap_in;
  assign strap_raw[3 + STRAP_SW] = chan_b_swing_strap_in;
  assign strap_raw[3 + STRAP_DE] = chan_b_deemph_strap_in;

  // Pads are asynchronous; two flops each
  for (genvar i = 0; i < NUM_STRAP; i++) begin : g_sync
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        strap_m[i] <= STRAP_OPEN;
        strap_s[i] <= STRAP_OPEN;
      end else begin
        strap_m[i] <= strap_raw[i];
        strap_s[i] <= strap_m[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      // Idle-high reset so release shows no false bus edge
      ctl_m <= 2'h3;
      ctl_s <= 2'h3;
      mode_m <= 2'h0;
      mode_s <= 2'h0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      // SCL shares the channel A swing pad, SDA the de-emphasis pad
      ctl_m <= {scl_in, sda_in};
      ctl_s <= ctl_m;
      mode_m <= {host_ctl_in, power_down_in};
      mode_s <= mode_m;
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign host_s = mode_s[1];
  assign pd_s = mode_s[0];
  assign scl_s = ctl_s[1];
  assign sda_s = ctl_s[0];
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
  // Open or high strap gives a one
  assign my_addr = {ADDR_UPPER, strap_s[3 + STRAP_SW] != STRAP_LOW,
                    strap_s[3 + STRAP_DE] != STRAP_LOW};
  assign byte_done = scl_fall && bit_q == BITS_BYTE;
  assign wr_commit = state_q == ST_WBYTE && byte_done && filler_q
                     && ptr_q != BYTE_PAST;
  // Bytes past channel B read as zero
  assign rd_next = (ptr_q == BYTE_CHAN_A) ? set_q[0] :
                   (ptr_q == BYTE_CHAN_B) ? set_q[1] : READ_PAST;

  // Straps must settle through the synchroniser before latching
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      settle_q <= 2'h0;
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      settle_q <= settle_q + 2'h1;
      loaded_q <= settle_q == STRAP_SETTLE;
    end
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        set_q[c] <= {EQ_OPEN, SW_RESET, DE_RESET};
      end else if (!loaded_q && settle_q == STRAP_SETTLE) begin
        set_q[c][EQ_MSB:EQ_LSB] <= map_eq(strap_s[3*c]);
      end else if (wr_commit && ptr_q == 2'(c)) begin
        set_q[c] <= shift_q;
      end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
        eq_q[c] <= EQ_OPEN;
        sw_q[c] <= SW_RESET;
        de_q[c] <= DE_RESET;
      end else if (host_s) begin
        eq_q[c] <= set_q[c][EQ_MSB:EQ_LSB];
        sw_q[c] <= set_q[c][SW_MSB:SW_LSB];
        de_q[c] <= set_q[c][DE_MSB:DE_LSB];
      end else begin
        eq_q[c] <= map_eq(strap_s[3*c + STRAP_EQ]);
        sw_q[c] <= map_sw(strap_s[3*c + STRAP_SW]);
        de_q[c] <= map_de(strap_s[3*c + STRAP_DE]);
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      chan_en_q <= 1'b0;
      term_q <= 1'b0;
      sda_zero_q <= 1'b0;
    end else begin
      chan_en_q <= ~pd_s;
      term_q <= ~pd_s;
      sda_zero_q <= 1'b0; // Open drain: data level always low
    end
  end

  // Data changes only after SCL falls; line is never stretched
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rd_q <= 8'h00;
      ptr_q <= BYTE_CHAN_A;
      rw_q <= 1'b0;
      filler_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (!host_s || !loaded_q || stop_det) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      bit_q <= 4'h0;
      ptr_q <= BYTE_CHAN_A;
      filler_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      if (scl_rise && (state_q == ST_ADDR || state_q == ST_WBYTE)) begin
        shift_q <= {shift_q[6:0], sda_s};
        bit_q <= bit_q + 4'h1;
      end
      if (scl_rise && state_q == ST_RACK) begin
        nack_q <= sda_s;
      end
      if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (byte_done) begin
              if (shift_q[7:1] == my_addr) begin
                state_q <= ST_AACK;
                rw_q <= shift_q[0];
                sda_oe_q <= 1'b1;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_q <= 4'h0;
            if (rw_q) begin
              state_q <= ST_RBYTE;
              rd_q <= rd_next;
              sda_oe_q <= ~rd_next[7];
            end else begin
              state_q <= ST_WBYTE;
              sda_oe_q <= 1'b0;
            end
          end
          ST_WBYTE: begin
            if (byte_done) begin
              state_q <= ST_WACK;
              sda_oe_q <= 1'b1;
              if (!filler_q) begin
                filler_q <= 1'b1;
              end else if (ptr_q != BYTE_PAST) begin
                ptr_q <= ptr_q + 2'h1;
              end
            end
          end
          ST_WACK: begin
            state_q <= ST_WBYTE;
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
          end
          ST_RBYTE: begin
            if (bit_q[2:0] == LAST_RD_BIT) begin
              state_q <= ST_RACK;
              sda_oe_q <= 1'b0;
              if (ptr_q != BYTE_PAST) begin
                ptr_q <= ptr_q + 2'h1;
              end
            end else begin
              rd_q <= {rd_q[6:0], 1'b0};
              sda_oe_q <= ~rd_q[6];
              bit_q <= bit_q + 4'h1;
            end
          end
          ST_RACK: begin
            bit_q <= 4'h0;
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RBYTE;
              rd_q <= rd_next;
              sda_oe_q <= ~rd_next[7];
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign sda_out = sda_zero_q;
  assign sda_oe_out = sda_oe_q;
  assign chan_a_eq_out = eq_q[0];
  assign chan_a_swing_out = sw_q[0];
  assign chan_a_deemph_out = de_q[0];
  assign chan_b_eq_out = eq_q[1];
  assign chan_b_swing_out = sw_q[1];
  assign chan_b_deemph_out = de_q[1];
  assign chan_enable_out = chan_en_q;
  assign in_term_50_out = term_q;
  assign out_term_50_out = term_q;

  chk_serial_eq: assert property (
    host_s ##1 host_s |-> chan_b_eq_out == $past(set_q[1][7:4]))
    else $error("serial eq not applied");
  chk_strap_eq: assert property (
    !host_s && strap_s[STRAP_EQ] == STRAP_HIGH |=> chan_a_eq_out == EQ_HIGH)
    else $error("eq strap high not mapped");
  chk_strap_swing: assert property (
    !host_s && strap_s[STRAP_SW] == STRAP_OPEN |=> chan_a_swing_out == SW_OPEN)
    else $error("swing strap open not mapped");
  chk_strap_deemph: assert property (
    !host_s && strap_s[5] == STRAP_LOW |=> chan_b_deemph_out == DE_LOW)
    else $error("deemph strap low not mapped");
  chk_power_down: assert property (
    pd_s ##1 pd_s |-> !chan_enable_out && !in_term_50_out && !out_term_50_out)
    else $error("power down not applied");
  chk_power_up: assert property (
    $fell(pd_s) |=> chan_enable_out && in_term_50_out && out_term_50_out)
    else $error("power up not applied");
  chk_filler_skip: assert property (
    state_q == ST_WBYTE && byte_done && !filler_q && host_s && !stop_det
    |=> set_q[0] == $past(set_q[0]) && set_q[1] == $past(set_q[1]))
    else $error("filler byte was stored");
  chk_addr_miss: assert property (
    state_q == ST_ADDR && byte_done && shift_q[7:1] != my_addr
    |=> !sda_oe_out [*2])
    else $error("acked a foreign address");
  chk_strap_latch: assert property (
    $rose(loaded_q) |-> set_q[0][7:4] == map_eq($past(strap_s[STRAP_EQ])))
    else $error("eq not latched from strap");

  cov_write: cover property (wr_commit);
  cov_read: cover property (state_q == ST_RACK && scl_fall && !nack_q);
  cov_pd: cover property ($rose(pd_s) ##[1:8] !chan_enable_out);
endmodule
`default_nettype wire

// [design/lss_pkg.sv]
// Purpose: Constants for the lane setting select block
// Assumes: Strap pads report a 2-bit resolved level
// Notes:   Codes follow the channel setting byte layout
package lss_pkg;
  localparam int NUM_CHAN = 2;
  localparam int NUM_STRAP = 6;
  localparam int STRAP_W = 2;
  // Resolved strap levels
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  // Strap index inside a channel group
  localparam int STRAP_EQ = 0;
  localparam int STRAP_SW = 1;
  localparam int STRAP_DE = 2;
  // Strap level to serial code
  localparam logic [3:0] EQ_LOW = 4'h1;
  localparam logic [3:0] EQ_OPEN = 4'h6;
  localparam logic [3:0] EQ_HIGH = 4'hb;
  localparam logic [1:0] SW_LOW = 2'h0;
  localparam logic [1:0] SW_OPEN = 2'h1;
  localparam logic [1:0] SW_HIGH = 2'h3;
  localparam logic [1:0] DE_LOW = 2'h0;
  localparam logic [1:0] DE_OPEN = 2'h2;
  localparam logic [1:0] DE_HIGH = 2'h3;
  // Setting byte fields and reset values
  localparam int EQ_MSB = 7;
  localparam int EQ_LSB = 4;
  localparam int SW_MSB = 3;
  localparam int SW_LSB = 2;
  localparam int DE_MSB = 1;
  localparam int DE_LSB = 0;
  localparam logic [1:0] SW_RESET = 2'h1;
  localparam logic [1:0] DE_RESET = 2'h2;
  // Byte indices
  localparam logic [1:0] BYTE_CHAN_A = 2'h0;
  localparam logic [1:0] BYTE_CHAN_B = 2'h1;
  localparam logic [1:0] BYTE_PAST = 2'h2;
  localparam logic [7:0] READ_PAST = 8'h00;
  // Serial port
  localparam logic [4:0] ADDR_UPPER = 5'h18;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [2:0] LAST_RD_BIT = 3'h7;
  // Cycles after reset before straps are latched
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK
  } lss_state_t;
endpackage

// [testbench/lss_i2c_master.sv]
// Purpose: Serial bus master model on the shared channel A strap pads
// Assumes: SCL period of eight system clocks (160 ns)
// Notes:   Bus stands high between frames; SDA has a pull-up
`timescale 1ns/1ns
`default_nettype none
module lss_i2c_master (
  input  wire logic clk_in,
  input  wire logic sda_oe_in,
  input  wire logic sda_drv_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic sda_q;
  initial begin
    scl_out = 1'b1;
    sda_q   = 1'b1;
  end
  // Wired-and: pull-up unless either side pulls low
  assign sda_out = sda_q & (sda_oe_in ? sda_drv_in : 1'b1);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves mid-low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_q <= b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    r = sda_out;
    scl_out <= 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_q <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_q <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_q <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_q <= 1'b1;
    tick(8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// [testbench/lss_lane_setting_select_bench.sv]
// Purpose: Self-checking bench for the lane setting select block
// Assumes: Strap levels coded low/open/high as in the package
// Notes:   Serial traffic comes from the master model
`timescale 1ns/1ns
`default_nettype none
module lss_lane_setting_select_bench;
  import lss_pkg::*;
  logic       clk_sys, reset, host_ctl, power_down;
  logic [1:0] st [6];
  logic       scl, sda, oe, drv, en, ti, to;
  logic [3:0] eq_a, eq_b;
  logic [1:0] sw_a, sw_b, de_a, de_b;
  logic [7:0] set_a, set_b;
  int         err_total, tests_run;
  assign set_a = {eq_a, sw_a, de_a};
  assign set_b = {eq_b, sw_b, de_b};
  lss_lane_setting_select i_dut (
    .clk_sys_in(clk_sys), .reset_in(reset), .host_ctl_in(host_ctl),
    .power_down_in(power_down), .chan_a_equalizer_strap_in(st[0]),
    .chan_a_swing_strap_in(st[1]), .chan_a_deemph_strap_in(st[2]),
    .chan_b_equalizer_strap_in(st[3]), .chan_b_swing_strap_in(st[4]),
    .chan_b_deemph_strap_in(st[5]), .scl_in(scl), .sda_in(sda),
    .sda_out(drv), .sda_oe_out(oe), .chan_a_eq_out(eq_a),
    .chan_a_swing_out(sw_a), .chan_a_deemph_out(de_a),
    .chan_b_eq_out(eq_b), .chan_b_swing_out(sw_b),
    .chan_b_deemph_out(de_b), .chan_enable_out(en),
    .in_term_50_out(ti), .out_term_50_out(to));
  lss_i2c_master i_host (
    .clk_in(clk_sys), .sda_oe_in(oe), .sda_drv_in(drv),
    .scl_out(scl), .sda_out(sda));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Literal codes kept apart from the package on purpose
  function automatic logic [7:0] strap_code(input logic [1:0] e, s, d);
    logic [3:0] q;
    logic [1:0] w, m;
    q = e == 2'h0 ? 4'h1 : e == 2'h2 ? 4'hb : 4'h6;
    w = s == 2'h0 ? 2'h0 : s == 2'h2 ? 2'h3 : 2'h1;
    m = d == 2'h0 ? 2'h0 : d == 2'h2 ? 2'h3 : 2'h2;
    return {q, w, m};
  endfunction
  task automatic xfer_write(input logic [6:0] a, input logic [7:0] x, y,
                            output logic k);
    logic j;
    i_host.start();
    i_host.send({a, 1'b0}, k);
    i_host.send(8'h5a, j);
    i_host.send(x, j);
    i_host.send(y, j);
    i_host.stop();
    wait_clk(4);
  endtask
  task automatic test_power_on;
    check(set_a, 8'hb6);
    check(set_b, 8'h16);
    check({5'h0, en, ti, to}, 8'h07);
    $display("test_power_on done");
  endtask
  task automatic test_write;
    logic [7:0] tbl [4] = '{8'hff, 8'haa, 8'h55, 8'h00};
    logic       k;
    for (int i = 0; i < 4; i++) begin
      xfer_write(7'h63, tbl[i], ~tbl[i], k);
      check({7'h0, k}, 8'h01);
      check(set_a, tbl[i]);
      check(set_b, ~tbl[i]);
    end
    $display("test_write done");
  endtask
  task automatic test_read;
    logic [7:0] d;
    logic       k;
    i_host.start();
    i_host.send(8'hc3, k);
    check({7'h0, k}, 8'h01);
    i_host.recv(1'b0, d);
    check(d, 8'h3c);
    i_host.recv(1'b0, d);
    check(d, 8'hc3);
    i_host.recv(1'b1, d);
    check(d, 8'h00);
    i_host.stop();
    $display("test_read done");
  endtask
  task automatic test_addr;
    logic k;
    st[4] <= STRAP_LOW;
    st[5] <= STRAP_HIGH;
    wait_clk(6);
    xfer_write(7'h63, 8'h3c, 8'hc3, k);
    check({7'h0, k}, 8'h00);
    check(set_a, 8'h00);
    xfer_write(7'h61, 8'h3c, 8'hc3, k);
    check({7'h0, k}, 8'h01);
    check(set_a, 8'h3c);
    check(set_b, 8'hc3);
    $display("test_addr done");
  endtask
  task automatic test_strap;
    logic [1:0] l, h;
    host_ctl <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      l = 2'(i);
      h = 2'(3 - i);
      for (int s = 0; s < 3; s++) begin
        st[s] <= l;
        st[s + 3] <= h;
      end
      wait_clk(8);
      check(set_a, strap_code(l, l, l));
      check(set_b, strap_code(h, h, h));
    end
    $display("test_strap done");
  endtask
  task automatic test_power_down;
    power_down <= 1'b1;
    wait_clk(6);
    check({5'h0, en, ti, to}, 8'h00);
    power_down <= 1'b0;
    wait_clk(6);
    check({5'h0, en, ti, to}, 8'h07);
    $display("test_power_down done");
  endtask
  // Whole run is a few thousand clocks; allow ample margin
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
  initial begin
    err_total = 0;
    tests_run = 0;
    reset = 1'b1;
    host_ctl = 1'b1;
    power_down = 1'b0;
    st = '{STRAP_HIGH, STRAP_OPEN, STRAP_OPEN,
           STRAP_LOW, STRAP_OPEN, STRAP_OPEN};
    wait_clk(3);
    reset <= 1'b0;
    wait_clk(10);
    test_power_on;
    test_write;
    test_addr;
    test_read;
    test_strap;
    test_power_down;
    wrap_up;
  end
endmodule
`default_nettype wire
